// ===== hw/clock_status_pkg.sv
// Constants shared by the status and control register block.
// Assumes an 8-bit register address space behind the serial port.
package clock_status_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h4C;
   localparam logic [7:0] LATCHED_ADDR = 8'h50;
   localparam logic [7:0] MOMENTARY_ADDR = 8'h51;
   localparam logic [7:0] CAL_STATUS_ADDR = 8'h53;
   localparam logic [7:0] DIVIDER_INIT_TRIGGER_ADDR = 8'h55;
   localparam logic [7:0] PLL_LOCK_RESTART_ADDR = 8'h56;
   localparam logic [7:0] BIAS_CALIBRATION_TRIGGER_ADDR = 8'h57;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int STATUS_BITS = 6;
   localparam int INPUT0_BIT = 0;
   localparam int INPUT1_BIT = 1;
   localparam int HOLDOVER_BIT = 2;
   localparam int REFERENCE_BIT = 3;
   localparam int JITTER_PLL_BIT = 4;
   localparam int SYNTH_BIT = 5;
   localparam int SELECTED_INPUT_BIT = 6;
   localparam int CAL_BUSY_BIT = 2;
   localparam int TRIGGER_BIT = 7;

   // ----------------------------------------------------------------
   // Values after reset and for unmapped reads
   // ----------------------------------------------------------------
   localparam logic [5:0] IRQ_ENABLE_RESET = 6'h00;
   localparam logic [5:0] FAULT_SEEN_RESET = 6'h00;
   localparam logic [7:0] READ_DATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ===== hw/sticky_fault_bank.sv
// Bank of sticky fault flags, one per monitored condition.
// Assumes fault and clear are synchronous to clk; set wins over clear.
`timescale 1ns/1ps

module sticky_fault_bank #(
   parameter int WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] fault,
   input wire logic [WIDTH-1:0] clear,
   output logic [WIDTH-1:0] seen
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
      $error("sticky_fault_bank: WIDTH must lie in 1 to 32");
   end

   typedef struct packed {
      logic [WIDTH-1:0] seen;
   } state_type;

   state_type st;
   state_type next_st;

   // Hold, clear on request, a present fault re-latches at once
   always_comb begin
      next_st = st;
      next_st.seen = (st.seen & ~clear) | fault;
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign seen = st.seen;

endmodule // sticky_fault_bank

// ===== hw/clock_status_and_control_regs.sv
// Status, latched status, interrupt enable and trigger registers.
// Assumes the serial port front end delivers single-cycle register
// read and write strobes with address and data, synchronous to clk.
//
// Summary of operation
// - Latched input-loss bit reads 0 after any loss since its clear.
// - Selected-input bit shows the reference in use: 0 first, 1 second.
// - Momentary synth lock bit reads 0 on loss of lock; latched too.
// - Momentary jitter PLL lock bit reads 0 on loss; latched too.
// - Momentary input-activity bits read 0 on loss of signal.
// - Latched reference bit reads 0 if the reference was ever lost.
// - Writing 1 clears the reference latch and its interrupt.
// - Latched holdover bit reads 0 once holdover was entered.
// - Writing 1 clears the holdover latch and its interrupt.
// - Reference-present bit reads 1 when the chosen input has one.
// - Momentary holdover bit reads 0 while in holdover.
// - Calibration status reads 1 while synth calibration runs.
// - Writing bit 7 of the divider trigger initialises dividers.
// - Writing 1 to the pll_lock_restart trigger forces pll_lock_restart; self-clearing.
// - Bias calibration trigger starts it, clears itself when done.
// - Enabled latched status drives the interrupt output low.
// - Latched synth lock bit records loss; writing 1 clears it.
`timescale 1ns/1ps

module clock_status_and_control_regs (
   input wire logic clk,
   input wire logic rst,
   // Register access from the serial port front end
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Momentary status from the clock core
   input wire logic [1:0] input_active_now,
   input wire logic selected_input_status,
   input wire logic synth_lock_ok_now,
   input wire logic jitter_pll_lock_ok_now,
   input wire logic reference_present_now,
   input wire logic no_holdover_now,
   input wire logic synth_cal_busy,
   input wire logic bias_cal_done,
   // Actions toward the clock core
   output logic divider_init,
   output logic pll_lock_restart,
   output logic bias_cal_trigger,
   // Interrupt pin, low while an enabled event is pending
   output logic interrupt_out_n
);

   typedef struct packed {
      logic [5:0] irq_enable;
      logic [7:0] rdata;
      logic divider_init;
      logic pll_lock_restart;
      logic bias_cal_trigger;
      logic irq_n;
   } state_type;

   state_type st;
   state_type next_st;

   logic [5:0] momentary_ok;
   logic [5:0] fault_now;
   logic [5:0] clear_req;
   logic [5:0] fault_seen;
   logic [5:0] latched_ok;
   logic [7:0] read_mux;
   logic wr_enable_reg;
   logic wr_latched_reg;
   logic wr_div_init;
   logic wr_pll_lock_restart;
   logic wr_bias_cal;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------

   // Address match per writable register
   assign wr_enable_reg = reg_wr &&
      (reg_addr == clock_status_pkg::IRQ_ENABLE_ADDR);
   assign wr_latched_reg = reg_wr &&
      (reg_addr == clock_status_pkg::LATCHED_ADDR);
   assign wr_div_init = reg_wr &&
      (reg_addr == clock_status_pkg::DIVIDER_INIT_TRIGGER_ADDR) &&
      reg_wdata[clock_status_pkg::TRIGGER_BIT];
   assign wr_pll_lock_restart = reg_wr &&
      (reg_addr == clock_status_pkg::PLL_LOCK_RESTART_ADDR) &&
      reg_wdata[clock_status_pkg::TRIGGER_BIT];
   assign wr_bias_cal = reg_wr &&
      (reg_addr == clock_status_pkg::BIAS_CALIBRATION_TRIGGER_ADDR) &&
      reg_wdata[clock_status_pkg::TRIGGER_BIT];

   // ----------------------------------------------------------------
   // Status collection and latches
   // ----------------------------------------------------------------

   // Momentary ok bits in latched-register order
   always_comb begin
      momentary_ok = '0;
      momentary_ok[clock_status_pkg::INPUT0_BIT] = input_active_now[0];
      momentary_ok[clock_status_pkg::INPUT1_BIT] = input_active_now[1];
      momentary_ok[clock_status_pkg::HOLDOVER_BIT] = no_holdover_now;
      momentary_ok[clock_status_pkg::REFERENCE_BIT] =
         reference_present_now;
      momentary_ok[clock_status_pkg::JITTER_PLL_BIT] =
         jitter_pll_lock_ok_now;
      momentary_ok[clock_status_pkg::SYNTH_BIT] = synth_lock_ok_now;
   end

   // Fault is the absence of each ok condition
   assign fault_now = ~momentary_ok;

   // Write 1 to clear, only on the latched register
   assign clear_req = wr_latched_reg ? reg_wdata[5:0] : 6'h00;

   sticky_fault_bank #(
      .WIDTH(clock_status_pkg::STATUS_BITS)
   ) u_latches (
      .clk(clk),
      .rst(rst),
      .fault(fault_now),
      .clear(clear_req),
      .seen(fault_seen)
   );

   // Latched bits read 1 when nothing happened since clear
   assign latched_ok = ~fault_seen;

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------

   // Reserved and write-only bits read as zero
   always_comb begin
      read_mux = clock_status_pkg::UNMAPPED_READ;
      case (reg_addr)
         clock_status_pkg::IRQ_ENABLE_ADDR: begin
            read_mux = {2'h0, st.irq_enable};
         end
         clock_status_pkg::LATCHED_ADDR: begin
            read_mux = {2'h0, latched_ok};
         end
         clock_status_pkg::MOMENTARY_ADDR: begin
            read_mux = {1'b0, selected_input_status, momentary_ok};
         end
         clock_status_pkg::CAL_STATUS_ADDR: begin
            read_mux[clock_status_pkg::CAL_BUSY_BIT] = synth_cal_busy;
         end
         default: begin
            read_mux = clock_status_pkg::UNMAPPED_READ;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Enables, read data, triggers and interrupt pin
   always_comb begin
      next_st = st;
      if (wr_enable_reg) begin
         next_st.irq_enable = reg_wdata[5:0];
      end
      if (reg_rd) begin
         next_st.rdata = read_mux;
      end
      next_st.divider_init = wr_div_init;
      next_st.pll_lock_restart = wr_pll_lock_restart;
      if (wr_bias_cal) begin
         next_st.bias_cal_trigger = 1'b1;
      end else if (bias_cal_done) begin
         next_st.bias_cal_trigger = 1'b0;
      end
      next_st.irq_n = ~|(fault_seen & st.irq_enable);
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st.irq_enable <= clock_status_pkg::IRQ_ENABLE_RESET;
         st.rdata <= clock_status_pkg::READ_DATA_RESET;
         st.divider_init <= 1'b0;
         st.pll_lock_restart <= 1'b0;
         st.bias_cal_trigger <= 1'b0;
         st.irq_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   assign reg_rdata = st.rdata;
   assign divider_init = st.divider_init;
   assign pll_lock_restart = st.pll_lock_restart;
   assign bias_cal_trigger = st.bias_cal_trigger;
   assign interrupt_out_n = st.irq_n;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // Input loss is latched on the next edge
   property p_input_loss_latch;
      @(posedge clk) disable iff (rst)
      !input_active_now[0] |=> !latched_ok[0];
   endproperty
   a_input_loss_latch: assert property (p_input_loss_latch)
      else $error("input loss not latched");

   // Clear of an input latch; pin then held only by other events
   property p_input_clear;
      @(posedge clk) disable iff (rst)
      (wr_latched_reg && reg_wdata[1] && input_active_now[1])
         |=> latched_ok[1] ##1 (interrupt_out_n ||
         ($past(fault_seen & st.irq_enable) & 6'h3D) != 6'h00);
   endproperty
   a_input_clear: assert property (p_input_clear)
      else $error("input latch not cleared");

   // Reference latch clears on write of one
   property p_ref_clear;
      @(posedge clk) disable iff (rst)
      (wr_latched_reg && reg_wdata[3] && reference_present_now)
         |=> latched_ok[3];
   endproperty
   a_ref_clear: assert property (p_ref_clear)
      else $error("reference latch not cleared");

   // Holdover latch clears on write of one
   property p_hold_clear;
      @(posedge clk) disable iff (rst)
      (wr_latched_reg && reg_wdata[2] && no_holdover_now)
         |=> latched_ok[2];
   endproperty
   a_hold_clear: assert property (p_hold_clear)
      else $error("holdover latch not cleared");

   // Synth loss of lock stays latched after lock returns without a latched-register write
   property p_synth_latch;
      @(posedge clk) disable iff (rst)
      !synth_lock_ok_now ##1 (synth_lock_ok_now && !wr_latched_reg)
         |=> !latched_ok[5];
   endproperty
   a_synth_latch: assert property (p_synth_latch)
      else $error("synth loss of lock not held");

   // A latched jitter PLL fault survives unless cleared
   property p_hold_until_clear;
      @(posedge clk) disable iff (rst)
      (fault_seen[4] && !clear_req[4]) |=> fault_seen[4];
   endproperty
   a_hold_until_clear: assert property (p_hold_until_clear)
      else $error("latched fault dropped without clear");

   // Enabled pending event pulls the pin low next edge
   property p_irq_assert;
      @(posedge clk) disable iff (rst)
      (|(fault_seen & st.irq_enable)) |=> !interrupt_out_n;
   endproperty
   a_irq_assert: assert property (p_irq_assert)
      else $error("interrupt not asserted");

   // Pin released only two edges after a clear or an enable write
   property p_irq_release;
      @(posedge clk) disable iff (rst)
      $rose(interrupt_out_n) |-> $past(wr_latched_reg || wr_enable_reg, 2);
   endproperty
   a_irq_release: assert property (p_irq_release)
      else $error("interrupt released with event pending");

   // Divider init is a single-cycle pulse
   property p_div_init;
      @(posedge clk) disable iff (rst)
      wr_div_init |=> divider_init ##1 (!divider_init || $past(wr_div_init));
   endproperty
   a_div_init: assert property (p_div_init)
      else $error("divider init pulse wrong");

   // Pll_lock_restart trigger pulses then clears itself
   property p_pll_lock_restart;
      @(posedge clk) disable iff (rst)
      wr_pll_lock_restart ##1 !wr_pll_lock_restart |-> pll_lock_restart ##1 !pll_lock_restart;
   endproperty
   a_pll_lock_restart: assert property (p_pll_lock_restart)
      else $error("pll_lock_restart trigger not self-clearing");

   // Bias calibration holds until done
   property p_bias_cal;
      @(posedge clk) disable iff (rst)
      wr_bias_cal ##1 (!bias_cal_done && !wr_bias_cal)[*2]
         |-> bias_cal_trigger;
   endproperty
   a_bias_cal: assert property (p_bias_cal)
      else $error("bias calibration dropped early");

   // Done without a new write ends the calibration request
   property p_bias_done;
      @(posedge clk) disable iff (rst)
      (bias_cal_done && !wr_bias_cal) |=> !bias_cal_trigger;
   endproperty
   a_bias_done: assert property (p_bias_done)
      else $error("bias calibration not cleared");

   // Selected-input bit is returned on a momentary read
   property p_sel_read;
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == clock_status_pkg::MOMENTARY_ADDR)
         |=> reg_rdata[6] == $past(selected_input_status);
   endproperty
   a_sel_read: assert property (p_sel_read)
      else $error("selected input read wrong");

   // Input activity bits are returned on a momentary read
   property p_active_read;
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == clock_status_pkg::MOMENTARY_ADDR)
         |=> reg_rdata[1:0] == $past(input_active_now);
   endproperty
   a_active_read: assert property (p_active_read)
      else $error("input activity read wrong");

   // Calibration busy is returned in its bit
   property p_cal_read;
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == clock_status_pkg::CAL_STATUS_ADDR)
         |=> reg_rdata == {5'h00, $past(synth_cal_busy), 2'h0};
   endproperty
   a_cal_read: assert property (p_cal_read)
      else $error("calibration status read wrong");

endmodule // clock_status_and_control_regs

// ===== tb/clock_core_model.sv
// Behavioural model of the clock core that feeds the status registers.
// Assumes the bench sets status levels through set_status at falling edges.
`timescale 1ns/1ps

module clock_core_model #(
   parameter int BIAS_CAL_CYCLES = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic divider_init,
   input wire logic pll_lock_restart,
   input wire logic bias_cal_trigger,
   output logic [6:0] status,
   output logic synth_cal_busy,
   output logic bias_cal_done
);
   int init_pulses = 0;
   int restart_pulses = 0;
   int bias_cnt = 0;

   // All inputs healthy and locked at start
   initial begin
      status = 7'h3F;
      synth_cal_busy = 1'b0;
      bias_cal_done = 1'b0;
   end

   // Status levels as the bench requests them
   task automatic set_status(input logic [6:0] v, input logic busy);
      status = v;
      synth_cal_busy = busy;
   endtask

   // Cycles for which each action strobe is seen high
   always @(posedge clk) begin
      if (divider_init === 1'b1) init_pulses++;
      if (pll_lock_restart === 1'b1) restart_pulses++;
   end

   // Calibration ends a fixed time after the trigger rises
   always @(negedge clk) begin
      bias_cal_done = 1'b0;
      if (rst || bias_cal_trigger !== 1'b1) begin
         bias_cnt = 0;
      end else begin
         bias_cnt = bias_cnt + 1;
         if (bias_cnt == BIAS_CAL_CYCLES) bias_cal_done = 1'b1;
      end
   end
endmodule // clock_core_model

// ===== tb/clock_status_and_control_regs_tb.sv
// Self-checking bench for the status and control register block.
// Assumes the strobe register port and the package constants.
`timescale 1ns/1ps

module clock_status_and_control_regs_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [6:0] status;
   logic synth_cal_busy, bias_cal_done, divider_init;
   logic pll_lock_restart, bias_cal_trigger, interrupt_out_n;
   int error_cnt = 0;
   int num_checks = 0;

   // 50 MHz clock
   always #10 clk = ~clk;

   clock_status_and_control_regs i_clock_status_and_control_regs (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .input_active_now(status[1:0]), .selected_input_status(status[6]),
      .synth_lock_ok_now(status[5]), .jitter_pll_lock_ok_now(status[4]),
      .reference_present_now(status[3]), .no_holdover_now(status[2]),
      .synth_cal_busy(synth_cal_busy), .bias_cal_done(bias_cal_done),
      .divider_init(divider_init), .pll_lock_restart(pll_lock_restart),
      .bias_cal_trigger(bias_cal_trigger),
      .interrupt_out_n(interrupt_out_n));

   clock_core_model i_clock_core_model (
      .clk(clk), .rst(rst), .divider_init(divider_init),
      .pll_lock_restart(pll_lock_restart),
      .bias_cal_trigger(bias_cal_trigger), .status(status),
      .synth_cal_busy(synth_cal_busy), .bias_cal_done(bias_cal_done));

   // ----------------------------------------------------------------
   // Access and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
                        input string nm);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(nm, reg_rdata, exp);
   endtask

   task automatic st(input logic [6:0] v, input logic busy);
      @(negedge clk);
      i_clock_core_model.set_status(v, busy);
   endtask

   task automatic pin(input logic exp);
      chk("interrupt_out_n", {7'h00, interrupt_out_n}, {7'h00, exp});
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] m;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      rdchk(clock_status_pkg::IRQ_ENABLE_ADDR, 8'h00, "enables");
      rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3F, "latched");
      rdchk(8'h60, 8'h00, "unmapped");
      pin(1'b1);
      $display("test reset done");
      // Disabled source never pulls the pin
      st(7'h3D, 1'b0);
      st(7'h3F, 1'b0);
      repeat (3) @(negedge clk);
      pin(1'b1);
      rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3D, "latched");
      wr(clock_status_pkg::LATCHED_ADDR, 8'h02);
      rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3F, "latched");
      // Each source: enable, momentary, latch, write-0 keep, clear
      for (int i = 0; i < 6; i++) begin
         m = 8'h01 << i;
         wr(clock_status_pkg::IRQ_ENABLE_ADDR, m);
         st(7'h3F ^ m[6:0], 1'b0);
         rdchk(clock_status_pkg::MOMENTARY_ADDR,
               8'h3F ^ m, "now");
         st(7'h3F, 1'b0);
         rdchk(clock_status_pkg::LATCHED_ADDR,
               8'h3F ^ m, "seen");
         pin(1'b0);
         wr(clock_status_pkg::LATCHED_ADDR, 8'h3F ^ m);
         rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3F ^ m, "kept");
         wr(clock_status_pkg::LATCHED_ADDR, m);
         @(negedge clk);
         pin(1'b1);
         rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3F, "cleared");
      end
      $display("test sources done");
      // Two pending events, lasting fault re-latches on clear
      wr(clock_status_pkg::IRQ_ENABLE_ADDR, 8'h03);
      st(7'h3C, 1'b0);
      wr(clock_status_pkg::LATCHED_ADDR, 8'h01);
      rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3C, "relatch");
      st(7'h3F, 1'b0);
      wr(clock_status_pkg::LATCHED_ADDR, 8'h01);
      repeat (2) @(negedge clk);
      pin(1'b0);
      wr(clock_status_pkg::LATCHED_ADDR, 8'h02);
      @(negedge clk);
      pin(1'b1);
      $display("test pending done");
      // Selected input and calibration status
      st(7'h7F, 1'b1);
      rdchk(clock_status_pkg::MOMENTARY_ADDR, 8'h7F, "selected");
      rdchk(clock_status_pkg::CAL_STATUS_ADDR, 8'h04, "cal");
      st(7'h3F, 1'b0);
      rdchk(clock_status_pkg::CAL_STATUS_ADDR, 8'h00, "cal");
      rdchk(clock_status_pkg::LATCHED_ADDR, 8'h3F, "no latch");
      $display("test status done");
      // Trigger registers
      wr(clock_status_pkg::DIVIDER_INIT_TRIGGER_ADDR, 8'h80);
      wr(clock_status_pkg::DIVIDER_INIT_TRIGGER_ADDR, 8'h7F);
      wr(clock_status_pkg::PLL_LOCK_RESTART_ADDR, 8'h80);
      wr(clock_status_pkg::PLL_LOCK_RESTART_ADDR, 8'h80);
      wr(clock_status_pkg::PLL_LOCK_RESTART_ADDR, 8'h7F);
      repeat (2) @(negedge clk);
      chk("init", 8'(i_clock_core_model.init_pulses), 8'h01);
      chk("pll_lock_restart", 8'(i_clock_core_model.restart_pulses), 8'h02);
      rdchk(clock_status_pkg::PLL_LOCK_RESTART_ADDR, 8'h00, "wo");
      wr(clock_status_pkg::BIAS_CALIBRATION_TRIGGER_ADDR, 8'h80);
      chk("bias", {7'h00, bias_cal_trigger}, 8'h01);
      repeat (6) @(negedge clk);
      chk("bias", {7'h00, bias_cal_trigger}, 8'h01);
      repeat (4) @(negedge clk);
      chk("bias", {7'h00, bias_cal_trigger}, 8'h00);
      rdchk(clock_status_pkg::BIAS_CALIBRATION_TRIGGER_ADDR,
            8'h00, "wo");
      $display("test triggers done");
      complete_run();
   end

   // Watchdog well beyond the expected run
   initial begin
      #200000;
      error_cnt++;
      complete_run();
   end
endmodule // clock_status_and_control_regs_tb
